// ==== gdr_cfg.svh ====
/*
 register offsets, field positions, reset values and key codes for the gate
 driver control and status register bank. assumes inclusion by bare name.
*/
`ifndef GDR_CFG_SVH
`define GDR_CFG_SVH

`define GDR_ADDR_W 4
`define GDR_DATA_W 11
`define GDR_OFS_STATUS2 4'h1
`define GDR_OFS_CTRL 4'h2
`define GDR_OFS_HS 4'h3

`define GDR_BIT_SCOPE 10
`define GDR_BIT_UVDIS 9
`define GDR_BIT_GFDIS 8
`define GDR_BIT_OTREP 7
`define GDR_BIT_MODE_HI 6
`define GDR_BIT_MODE_LO 5
`define GDR_BIT_RECT 4
`define GDR_BIT_DIR 3
`define GDR_BIT_COAST 2
`define GDR_BIT_BRAKE 1
`define GDR_BIT_CLR 0

`define GDR_CTRL_RESET 11'h000
`define GDR_KEY_LOCK 3'h6
`define GDR_KEY_UNLOCK 3'h3
`define GDR_KEY_RESET 3'h3
`define GDR_CUR_RESET 4'hf
`define GDR_LOCKED_CTRL_MASK 11'h007

`endif

// ==== gdr_pkg.sv ====
/*
 types for the gate driver register bank.
 assumes gdr_cfg.svh is on the include path.
*/
package gdr_pkg;
   typedef enum logic [1:0] {
      GDR_PWM_SIX = 2'h0,
      GDR_PWM_THREE = 2'h1,
      GDR_PWM_SINGLE = 2'h2,
      GDR_PWM_INDEP = 2'h3
   } gdr_pwm_mode_t;

   // raw fault events from the analog monitors, one cycle or level
   typedef struct packed {
      logic [2:0] shunt_oc;      // a, b, c
      logic overtemp_warning;
      logic charge_pump_uv;
      logic low_side_reg_uv;
      logic [5:0] gate_fault;    // ah, al, bh, bl, ch, cl
      logic [2:0] drain_source_oc; // per half-bridge a, b, c
   } gdr_fault_in_t;

   // settings steering the analog and pwm logic
   typedef struct packed {
      gdr_pwm_mode_t pwm_mode;
      logic single_input_rectification;
      logic single_input_direction;
      logic coast;
      logic brake;
      logic [3:0] high_side_source_current;
      logic [3:0] high_side_sink_current;
      logic [2:0] bridge_shutdown;   // a, b, c
   } gdr_drive_out_t;

   typedef struct packed {
      logic [10:0] status2;
      logic [10:0] ctrl;
      logic [2:0] key;
      logic locked;
      logic [3:0] src_cur;
      logic [3:0] snk_cur;
      logic [10:0] rdata;
   } gdr_state_t;
endpackage

// ==== gdr_regs.sv ====
/*
 gate driver control and status register bank: second fault status word,
 driver control word and high-side drive word, with write lock.
 assumes fault inputs already synchronised to i_ref_clk by the analog wrapper
 and the direction/brake pins synchronised here.
*/
// Our own choice: strobed register access.
// Functional notes
// - shunt overcurrent a, b, c latch into status bits 10, 9, 8; reset zero
// - status bit 6 sets on charge pump or low-side regulator undervoltage
// - gate faults per mosfet in bits 5..0: ah, al, bh, bl, ch, cl
// - overcurrent shuts affected half-bridge, or all three when scope bit set
// - control bit 9 high suppresses gate supply undervoltage fault
// - control bit 8 high disables gate drive fault detection
// - overtemp warning bit 7 feeds fault summary only when control bit 7 set
// - bits 6-5 select pwm scheme: six, three, single, independent; reset six
// - single mode rectification: bit 4 low synchronous, high asynchronous
// - single mode direction is bit 3 or phase c high input
// - control bit 2 puts all gates in coast
// - control bit 1 turns on all low sides for braking
// - single mode brake is bit 1 or phase c low input
// - writing 1 to bit 0 clears latched faults; bit self-clears
// - key 110b locks; then only key and control bits 2-0 writable
// - non-lock key values have no locking effect while unlocked
// - key 011b unlocks; key resets to 011b
// - non-unlock key values have no unlocking effect while locked
// - fault summary is or of flags, mirrored active low on fault pin
`timescale 1ns/10ps
`include "gdr_cfg.svh"

module gdr_regs (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [`GDR_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire gdr_pkg::gdr_fault_in_t i_faults,
   input wire logic i_phase_c_high_input,
   input wire logic i_phase_c_low_input,
   output gdr_pkg::gdr_drive_out_t o_drive,
   output logic o_fault_summary,
   output logic o_fault_output_n
);
   import gdr_pkg::*;

   gdr_state_t r;
   gdr_state_t next_r;
   logic [1:0] dir_sync;
   logic [1:0] brk_sync;
   logic summary;
   logic [2:0] shut;
   logic single;

   // pins come from outside the clock domain
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         dir_sync <= 2'h0;
         brk_sync <= 2'h0;
      end else begin
         dir_sync <= {dir_sync[0], i_phase_c_high_input};
         brk_sync <= {brk_sync[0], i_phase_c_low_input};
      end
   end

   function automatic logic is_wr(input logic [`GDR_ADDR_W-1:0] ofs);
      return i_wr && (i_addr == ofs);
   endfunction

   always_comb begin
      logic [10:0] ev;
      logic [10:0] mask;
      logic clr;
      next_r = r;
      ev = 11'h000;
      mask = 11'h7ff;
      clr = 1'b0;
      ev[10:8] = i_faults.shunt_oc;
      ev[7] = i_faults.overtemp_warning;
      ev[6] = (i_faults.charge_pump_uv | i_faults.low_side_reg_uv) & ~r.ctrl[`GDR_BIT_UVDIS];
      ev[5:0] = i_faults.gate_fault & {6{~r.ctrl[`GDR_BIT_GFDIS]}};
      next_r.ctrl[`GDR_BIT_CLR] = 1'b0;
      if (is_wr(`GDR_OFS_CTRL)) begin
         if (r.locked) begin
            mask = `GDR_LOCKED_CTRL_MASK;
         end
         next_r.ctrl = (r.ctrl & ~mask) | (i_wdata[10:0] & mask);
         clr = i_wdata[`GDR_BIT_CLR];
         next_r.ctrl[`GDR_BIT_CLR] = 1'b0;
      end
      if (is_wr(`GDR_OFS_HS)) begin
         if (!r.locked) begin
            next_r.src_cur = i_wdata[7:4];
            next_r.snk_cur = i_wdata[3:0];
            if (i_wdata[10:8] == `GDR_KEY_LOCK) begin
               next_r.key = `GDR_KEY_LOCK;
               next_r.locked = 1'b1;
            end
         end else if (i_wdata[10:8] == `GDR_KEY_UNLOCK) begin
            next_r.key = `GDR_KEY_UNLOCK;
            next_r.locked = 1'b0;
         end
      end
      // status word is read only; writes to it fall through
      // set wins over clear for events arriving with the clear
      next_r.status2 = (clr ? 11'h000 : r.status2) | ev;
      next_r.rdata = 11'h000;
      if (i_rd) begin
         unique case (i_addr)
            `GDR_OFS_STATUS2: next_r.rdata = r.status2;
            `GDR_OFS_CTRL: next_r.rdata = r.ctrl;
            `GDR_OFS_HS: next_r.rdata = {r.key, r.src_cur, r.snk_cur};
            default: next_r.rdata = 11'h000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         r.status2 <= 11'h000;
         r.ctrl <= `GDR_CTRL_RESET;
         r.key <= `GDR_KEY_RESET;
         r.locked <= 1'b0;
         r.src_cur <= `GDR_CUR_RESET;
         r.snk_cur <= `GDR_CUR_RESET;
         r.rdata <= 11'h000;
      end else begin
         r <= next_r;
      end
   end

   assign o_rdata = {21'h00_0000, r.rdata};

   // overtemp only counts toward summary when reporting enabled
   assign summary = (|r.status2[10:8]) | (|r.status2[6:0]) |
                    (r.status2[7] & r.ctrl[`GDR_BIT_OTREP]);
   assign o_fault_summary = summary;
   assign o_fault_output_n = ~summary;

   // shutdown follows raw overcurrent so the bridge drops without a register delay
   assign shut = (i_faults.shunt_oc | i_faults.drain_source_oc);
   assign single = (r.ctrl[6:5] == GDR_PWM_SINGLE);

   always_comb begin
      o_drive.pwm_mode = gdr_pwm_mode_t'(r.ctrl[6:5]);
      o_drive.single_input_rectification = r.ctrl[`GDR_BIT_RECT];
      o_drive.single_input_direction = r.ctrl[`GDR_BIT_DIR] | (single & dir_sync[1]);
      o_drive.coast = r.ctrl[`GDR_BIT_COAST];
      o_drive.brake = r.ctrl[`GDR_BIT_BRAKE] | (single & brk_sync[1]);
      o_drive.high_side_source_current = r.src_cur;
      o_drive.high_side_sink_current = r.snk_cur;
      o_drive.bridge_shutdown = r.ctrl[`GDR_BIT_SCOPE] ? {3{|shut}} : shut;
   end

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence lock_seq;
      is_wr(`GDR_OFS_HS) && !r.locked && i_wdata[10:8] == `GDR_KEY_LOCK;
   endsequence

   sequence unlock_seq;
      is_wr(`GDR_OFS_HS) && r.locked && i_wdata[10:8] == `GDR_KEY_UNLOCK;
   endsequence

   // clear strobe with no event arriving beside it
   sequence quiet_clear_seq;
      is_wr(`GDR_OFS_CTRL) && i_wdata[`GDR_BIT_CLR] && i_faults.shunt_oc == 3'h0 &&
         !i_faults.overtemp_warning && !i_faults.charge_pump_uv && !i_faults.low_side_reg_uv &&
         i_faults.gate_fault == 6'h00;
   endsequence

   shunt_latch_a: assert property (i_faults.shunt_oc[2] |=> r.status2[10])
      else $error("shunt a flag not set");
   uv_flag_a: assert property ((i_faults.charge_pump_uv && !r.ctrl[9]) |=> r.status2[6])
      else $error("undervoltage flag not set");
   gate_fault_a: assert property ((i_faults.gate_fault[0] && !r.ctrl[8]) |=> r.status2[0])
      else $error("gate fault c low not set");
   scope_all_a: assert property ((r.ctrl[10] && |shut) |-> o_drive.bridge_shutdown == 3'h7)
      else $error("scope not all bridges");
   uv_disable_a: assert property ((r.ctrl[9] && !r.status2[6] && !i_wr) |=> !r.status2[6])
      else $error("undervoltage not suppressed");
   gf_disable_a: assert property ((r.ctrl[8] && r.status2[5:0] == 6'h0 && !i_wr) |=> r.status2[5:0] == 6'h0)
      else $error("gate fault not suppressed");
   otw_report_a: assert property ((r.status2 == 11'h080 && !r.ctrl[7]) |-> !o_fault_summary)
      else $error("overtemp reported while masked");
   clr_self_a: assert property (##1 !r.ctrl[0])
      else $error("clear bit stuck");
   lock_ctrl_a: assert property ((r.locked && is_wr(`GDR_OFS_CTRL)) |=> r.ctrl[10:3] == $past(r.ctrl[10:3]))
      else $error("locked control changed");
   lock_take_a: assert property (lock_seq |=> r.locked ##0 r.key == `GDR_KEY_LOCK)
      else $error("lock not taken");
   unlock_only_a: assert property ((r.locked && is_wr(`GDR_OFS_HS) && i_wdata[10:8] != `GDR_KEY_UNLOCK) |=> r.locked)
      else $error("unlocked without key");
   read_ctrl_a: assert property ((i_rd && i_addr == `GDR_OFS_CTRL) |=> o_rdata == {21'h00_0000, $past(r.ctrl)})
      else $error("control readback wrong");
   unlock_take_a: assert property (unlock_seq |=> !r.locked && r.key == `GDR_KEY_UNLOCK)
      else $error("unlock not taken");
   no_lock_a: assert property ((!r.locked && is_wr(`GDR_OFS_HS) && i_wdata[10:8] != `GDR_KEY_LOCK) |=> !r.locked)
      else $error("locked without key");
   locked_cur_a: assert property ((r.locked && is_wr(`GDR_OFS_HS)) |=> r.src_cur == $past(r.src_cur) && r.snk_cur == $past(r.snk_cur))
      else $error("currents changed while locked");
   clear_all_a: assert property (quiet_clear_seq |=> r.status2 == 11'h000)
      else $error("latched faults not cleared");
   set_wins_a: assert property ((is_wr(`GDR_OFS_CTRL) && i_wdata[`GDR_BIT_CLR] && i_faults.shunt_oc[0]) |=> r.status2[8])
      else $error("event lost to clear");
   status_ro_a: assert property ((is_wr(`GDR_OFS_STATUS2) && i_faults == '0) |=> r.status2 == $past(r.status2))
      else $error("status word written");
   fault_pin_a: assert property ((|r.status2[6:0]) |-> !o_fault_output_n && o_fault_summary)
      else $error("fault pin not asserted");
   rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
      else $error("read data not idle zero");
   single_brake_a: assert property ((single && brk_sync[1]) |-> o_drive.brake)
      else $error("brake pin ignored in single mode");
endmodule

// ==== gdr_host_model.sv ====
/*
 host model: register bus master for the gate driver register bank.
 assumes one clock; the bench calls wr and rd from its scenarios.
*/
`timescale 1ns/10ps
module gdr_host_model (
   input wire logic i_ref_clk,
   input wire logic [31:0] i_rdata,
   output logic [3:0] o_addr,
   output logic [31:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   initial begin
      o_addr = 4'h0;
      o_wdata = 32'h0000_0000;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   task automatic wr(input logic [3:0] a, input logic [10:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_wdata <= {21'h00_0000, d};
      o_wr <= 1'b1;
      @(posedge i_ref_clk);
      o_wr <= 1'b0;
      // idle bus drives the inverted write data, not the value just written
      o_wdata <= ~o_wdata;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_ref_clk);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
   endtask
endmodule

// ==== tb.sv ====
/*
 self-checking bench for the gate driver register bank.
 assumes gdr_cfg.svh on the include path and gdr_host_model as bus master.
*/
`timescale 1ns/10ps
module tb;
   import gdr_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] d;
   logic wr;
   logic rd;
   logic pin_h = 1'b0;
   logic pin_l = 1'b0;
   logic sum;
   logic flt_n;
   gdr_fault_in_t flt = '0;
   gdr_fault_in_t f;
   gdr_drive_out_t drv;
   int errors = 0;
   int comparisons = 0;

   always #2 i_ref_clk = ~i_ref_clk;

   gdr_regs i_gdr_regs (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_faults(flt), .i_phase_c_high_input(pin_h),
      .i_phase_c_low_input(pin_l), .o_drive(drv), .o_fault_summary(sum), .o_fault_output_n(flt_n));
   gdr_host_model i_gdr_host_model (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
      i_gdr_host_model.rd(a, d);
      chk(n, e, d);
   endtask

   // one-cycle events must latch
   task automatic pulse(input gdr_fault_in_t p);
      @(posedge i_ref_clk);
      flt <= p;
      @(posedge i_ref_clk);
      flt <= '0;
      @(posedge i_ref_clk);
      #1;
   endtask

   task automatic t_reset;
      rchk("status", 4'h1, 32'h0000_0000);
      rchk("ctrl", 4'h2, 32'h0000_0000);
      rchk("hs", 4'h3, 32'h0000_03ff);
      rchk("unmapped", 4'hf, 32'h0000_0000);
      chk("currents", 32'h0000_00ff, 32'({drv.high_side_source_current, drv.high_side_sink_current}));
      chk("fault_n", 32'h0000_0001, 32'(flt_n));
   endtask

   task automatic t_faults;
      f = '0;
      f.shunt_oc = 3'h5;
      f.gate_fault = 6'h21;
      f.low_side_reg_uv = 1'b1;
      pulse(f);
      rchk("status", 4'h1, 32'h0000_0561);
      chk("summary", 32'h0000_0001, 32'(sum));
      chk("fault_n", 32'h0000_0000, 32'(flt_n));
      i_gdr_host_model.wr(4'h2, 11'h001);
      rchk("cleared", 4'h1, 32'h0000_0000);
      rchk("clr bit", 4'h2, 32'h0000_0000);
      i_gdr_host_model.wr(4'h2, 11'h300);
      f = '0;
      f.charge_pump_uv = 1'b1;
      f.gate_fault = 6'h10;
      f.overtemp_warning = 1'b1;
      pulse(f);
      rchk("masked", 4'h1, 32'h0000_0080);
      chk("otw hidden", 32'h0000_0000, 32'(sum));
      i_gdr_host_model.wr(4'h2, 11'h080);
      chk("otw shown", 32'h0000_0000, 32'(flt_n));
      i_gdr_host_model.wr(4'h2, 11'h001);
   endtask

   task automatic t_drive;
      for (int m = 0; m < 4; m++) begin
         i_gdr_host_model.wr(4'h2, 11'(m << 5));
         chk("mode", 32'(m), 32'(drv.pwm_mode));
      end
      i_gdr_host_model.wr(4'h2, 11'h05e);
      chk("rect dir coast brake", 32'h0000_000f, 32'({drv.single_input_rectification,
         drv.single_input_direction, drv.coast, drv.brake}));
      i_gdr_host_model.wr(4'h2, 11'h040);
      @(posedge i_ref_clk);
      pin_h <= 1'b1;
      pin_l <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      #1;
      chk("pin dir brake", 32'h0000_0003, 32'({drv.single_input_direction, drv.brake}));
      i_gdr_host_model.wr(4'h2, 11'h000);
      chk("six mode pins", 32'h0000_0000, 32'({drv.single_input_direction, drv.brake}));
      pin_h <= 1'b0;
      pin_l <= 1'b0;
   endtask

   task automatic t_scope;
      @(posedge i_ref_clk);
      flt.drain_source_oc <= 3'h4;
      #1;
      chk("one bridge", 32'h0000_0004, 32'(drv.bridge_shutdown));
      i_gdr_host_model.wr(4'h2, 11'h400);
      chk("all bridges", 32'h0000_0007, 32'(drv.bridge_shutdown));
      flt <= '0;
      i_gdr_host_model.wr(4'h2, 11'h001);
   endtask

   task automatic t_lock;
      i_gdr_host_model.wr(4'h3, 11'h5a5);
      rchk("no lock", 4'h3, 32'h0000_03a5);
      i_gdr_host_model.wr(4'h3, 11'h612);
      rchk("locked", 4'h3, 32'h0000_0612);
      i_gdr_host_model.wr(4'h3, 11'h5ff);
      rchk("no unlock", 4'h3, 32'h0000_0612);
      i_gdr_host_model.wr(4'h2, 11'h7fe);
      rchk("ctrl low bits", 4'h2, 32'h0000_0006);
      i_gdr_host_model.wr(4'h1, 11'h7ff);
      rchk("status ro", 4'h1, 32'h0000_0000);
      i_gdr_host_model.wr(4'h3, 11'h3ff);
      rchk("unlocked", 4'h3, 32'h0000_0312);
      i_gdr_host_model.wr(4'h3, 11'h0cc);
      rchk("currents", 4'h3, 32'h0000_03cc);
   endtask

   task automatic print_verdict;
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // the run is under a hundred cycles; this only cuts a hang
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      errors++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_reset();
      t_faults();
      t_drive();
      t_scope();
      t_lock();
      print_verdict();
   end
endmodule
